/* rtl/prbacc_core.sv */
// Purpose : Host access to the packet RAM through a pointer and a data port
// Assumes : Host strobes are synchronous to clock, one cycle long
// Notes   : Host always wins arbitration over the protocol engine
//
// What this block does
// - Host reaches packet RAM only through one byte wide data port.
// - Upper pointer written first; writing lower pointer loads the address.
// - Loading the pointer prefetches the addressed byte into the data port.
// - With auto increment set, each data access bumps pointer; reads prefetch next.
// - Host data writes land in a temporary register, committed to RAM later.
// - Slow arbitration bit in setup register halves the arbitration clock.
// - Pointer registers read back the current, incremented address.
// - RAM is four 512 byte pages; command page field picks the page.
// - Command offset bit 5 adds 256 bytes to the page start.
// - Buffer start equals page times 512 plus offset bit times 256.
// - Command byte 0010 0011 enables transmit from upper half of page zero.
// - Receive writes are never checked against page boundaries.
// - Page byte 0 source id, byte 1 destination id, byte 2 short count.
// - Long packets: byte 2 zero, byte 3 holds 512 minus length.
// - On transmit the device supplies its own node id for page byte 0.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module prbacc_core #(
	parameter int ADDR_W = 11,
	parameter int DEPTH  = 2048
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              nrst,
	// Register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [7:0]             reg_rdata,
	// Protocol engine memory port
	input  wire logic              eng_req,
	input  wire logic              eng_we,
	input  wire logic              eng_tx_read,
	input  wire logic [ADDR_W-1:0] eng_addr,
	input  wire logic [7:0]        eng_wdata,
	output logic                   eng_ack,
	output logic [7:0]             eng_rdata,
	// Page selection and header decode
	output logic                   tx_enable_pulse,
	output logic                   rx_enable_pulse,
	output logic [ADDR_W-1:0]      tx_page_start,
	output logic [ADDR_W-1:0]      rx_page_start,
	output logic                   tx_is_long,
	output logic [ADDR_W-1:0]      tx_first_data,
	output logic [9:0]             tx_data_len
);
	import prbacc_pkg::*;

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	// Start of a buffer from the command word page field and offset bit
	function automatic logic [ADDR_W-1:0] page_start(input logic [7:0] cmd);
		return ADDR_W'(cmd[CMD_PAGE_LSB +: 2]) * PAGE_BYTES +
			(cmd[CMD_OFFSET_BIT] ? HALF_PAGE_BYTES : '0);
	endfunction
	// Data length from the count bytes of the header
	function automatic logic [9:0] hdr_len(input logic lng, input logic [7:0] c2,
		input logic [7:0] c3);
		return lng ? (LONG_SPAN - 10'(c3)) : (SHORT_SPAN - 10'(c2));
	endfunction

	// ****************************************************************
	// Storage and state
	// ****************************************************************
	logic [7:0]        mem_ff [DEPTH];
	logic [7:0]        upper_ff;
	logic [ADDR_W-1:0] ptr_ff;
	logic [7:0]        tmp_ff;
	logic              host_pend_ff;
	logic              host_we_ff;
	logic [ADDR_W-1:0] host_addr_ff;
	logic [7:0]        first_setup_register_ff;
	logic [7:0]        pkt_cfg_ff;
	logic [7:0]        node_id_ff;
	logic [7:0]        rdata_ff;
	logic              arb_tog_ff;
	logic              eng_ack_ff;
	logic [7:0]        eng_rdata_ff;
	logic [ADDR_W-1:0] tx_start_ff;
	logic [ADDR_W-1:0] rx_start_ff;
	logic              tx_pulse_ff;
	logic              rx_pulse_ff;
	logic [7:0]        cnt2_ff;
	logic [7:0]        cnt3_ff;

	logic wr_upper, wr_lower, wr_data, rd_data, wr_cmd;
	logic arb_en, host_go, eng_go, long_pkt;
	logic [ADDR_W-1:0] nxt_ptr;

	assign wr_upper = reg_wr && (reg_addr == OFS_PTR_UPPER);
	assign wr_lower = reg_wr && (reg_addr == OFS_PTR_LOWER);
	assign wr_data  = reg_wr && (reg_addr == OFS_DATA_PORT);
	assign rd_data  = reg_rd && (reg_addr == OFS_DATA_PORT);
	assign wr_cmd   = reg_wr && (reg_addr == OFS_COMMAND);
	assign long_pkt = pkt_cfg_ff[PKTCFG_LONG_BIT];

	// ****************************************************************
	// Arbitration clock enable
	// ****************************************************************
	// Halving only thins the grant slots; the block stays on one clock
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			arb_tog_ff <= 1'b0;
		end else begin
			arb_tog_ff <= ~arb_tog_ff;
		end
	end
	assign arb_en  = first_setup_register_ff[FIRST_SETUP_REGISTER_HALVED_ARBITRATION_CLOCK_BIT] ? arb_tog_ff : 1'b1;
	// Host first: its one pending byte must clear before the next strobe
	assign host_go = arb_en && host_pend_ff;
	assign eng_go  = arb_en && !host_pend_ff && eng_req;

	// ****************************************************************
	// Pointer and configuration registers
	// ****************************************************************
	// Any data port access steps the pointer when auto increment is on
	always_comb begin
		nxt_ptr = ptr_ff;
		if (wr_lower) begin
			nxt_ptr = {upper_ff[ADDR_W-9:0], reg_wdata};
		end else if ((wr_data || rd_data) && upper_ff[UPPER_AUTO_INC_BIT]) begin
			nxt_ptr = ptr_ff + ADDR_W'(1);
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ptr_ff   <= '0;
			upper_ff <= RESET_BYTE;
		end else begin
			ptr_ff <= nxt_ptr;
			if (wr_upper) begin
				upper_ff <= reg_wdata; // Held until the lower byte arrives
			end
		end
	end

	// Setup, node id and packet configuration
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			first_setup_register_ff  <= RESET_BYTE;
			pkt_cfg_ff <= RESET_BYTE;
			node_id_ff <= RESET_BYTE;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_FIRST_SETUP_REGISTER:     first_setup_register_ff  <= reg_wdata;
				OFS_PKT_CONFIG: pkt_cfg_ff <= reg_wdata;
				OFS_NODE_ID:    node_id_ff <= reg_wdata;
				default:        ;
			endcase
		end
	end

	// ****************************************************************
	// Host pending operation and temporary register
	// ****************************************************************
	// A newer host request replaces the old one, so the host must
	// reload the pointer before switching direction
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			host_pend_ff <= 1'b0;
			host_we_ff   <= 1'b0;
			host_addr_ff <= '0;
		end else if (wr_lower) begin
			host_pend_ff <= 1'b1;
			host_we_ff   <= 1'b0;
			host_addr_ff <= nxt_ptr;
		end else if (wr_data) begin
			host_pend_ff <= 1'b1;
			host_we_ff   <= 1'b1;
			host_addr_ff <= ptr_ff;
		end else if (rd_data && upper_ff[UPPER_AUTO_INC_BIT]) begin
			host_pend_ff <= 1'b1;
			host_we_ff   <= 1'b0;
			host_addr_ff <= nxt_ptr;
		end else if (host_go) begin
			host_pend_ff <= 1'b0;
		end
	end

	// Temporary register: prefetched byte or byte awaiting commit
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tmp_ff <= RESET_BYTE;
		end else if (wr_data) begin
			tmp_ff <= reg_wdata;
		end else if (host_go && !host_we_ff) begin
			tmp_ff <= mem_ff[host_addr_ff];
		end
	end

	// ****************************************************************
	// Packet RAM
	// ****************************************************************
	// Engine addresses wrap freely; no page boundary is enforced
	always_ff @(posedge clock) begin
		if (host_go && host_we_ff) begin
			mem_ff[host_addr_ff] <= tmp_ff;
		end else if (eng_go && eng_we) begin
			mem_ff[eng_addr] <= eng_wdata;
		end
	end

	// Engine answer; transmit fetch of byte 0 gets our own node id
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			eng_ack_ff   <= 1'b0;
			eng_rdata_ff <= RESET_BYTE;
		end else begin
			eng_ack_ff <= eng_go;
			if (eng_go && !eng_we) begin
				if (eng_tx_read && (eng_addr == tx_start_ff + HDR_SRC_ID)) begin
					eng_rdata_ff <= node_id_ff;
				end else begin
					eng_rdata_ff <= mem_ff[eng_addr];
				end
			end
		end
	end

	// ****************************************************************
	// Command decode and header capture
	// ****************************************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tx_start_ff <= '0;
			rx_start_ff <= '0;
			tx_pulse_ff <= 1'b0;
			rx_pulse_ff <= 1'b0;
		end else begin
			tx_pulse_ff <= wr_cmd && (reg_wdata[2:0] == CMD_ENABLE_TX);
			rx_pulse_ff <= wr_cmd && (reg_wdata[2:0] == CMD_ENABLE_RX);
			if (wr_cmd && (reg_wdata[2:0] == CMD_ENABLE_TX)) begin
				tx_start_ff <= page_start(reg_wdata);
			end
			if (wr_cmd && (reg_wdata[2:0] == CMD_ENABLE_RX)) begin
				rx_start_ff <= page_start(reg_wdata);
			end
		end
	end

	// Count bytes seen while the engine fetches the transmit header
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt2_ff <= RESET_BYTE;
			cnt3_ff <= RESET_BYTE;
		end else if (eng_go && !eng_we && eng_tx_read) begin
			if (eng_addr == tx_start_ff + HDR_SHORT_COUNT) begin
				cnt2_ff <= mem_ff[eng_addr];
			end
			if (eng_addr == tx_start_ff + HDR_LONG_COUNT) begin
				cnt3_ff <= mem_ff[eng_addr];
			end
		end
	end

	// Zero short count marks a long packet only when long packets are on
	assign tx_is_long    = long_pkt && (cnt2_ff == RESET_BYTE);
	assign tx_first_data = tx_start_ff + ADDR_W'(tx_is_long ? cnt3_ff : cnt2_ff);
	assign tx_data_len   = hdr_len(tx_is_long, cnt2_ff, cnt3_ff);

	// ****************************************************************
	// Register read port
	// ****************************************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= RESET_BYTE;
		end else if (reg_rd) begin
			case (reg_addr)
				OFS_PTR_UPPER:  rdata_ff <= {upper_ff[7:ADDR_W-8], ptr_ff[ADDR_W-1:8]};
				OFS_PTR_LOWER:  rdata_ff <= ptr_ff[7:0];
				OFS_DATA_PORT:  rdata_ff <= tmp_ff;
				OFS_FIRST_SETUP_REGISTER:     rdata_ff <= first_setup_register_ff;
				OFS_PKT_CONFIG: rdata_ff <= pkt_cfg_ff;
				OFS_NODE_ID:    rdata_ff <= node_id_ff;
				default:        rdata_ff <= RESET_BYTE;
			endcase
		end else begin
			rdata_ff <= RESET_BYTE; // Read data stands one cycle only
		end
	end

	assign reg_rdata       = rdata_ff;
	assign eng_ack         = eng_ack_ff;
	assign eng_rdata       = eng_rdata_ff;
	assign tx_enable_pulse = tx_pulse_ff;
	assign rx_enable_pulse = rx_pulse_ff;
	assign tx_page_start   = tx_start_ff;
	assign rx_page_start   = rx_start_ff;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_lower_loads_ptr: assert property (@(posedge clock) disable iff (!nrst)
		wr_lower |=> ptr_ff == {$past(upper_ff[2:0]), $past(reg_wdata)})
		else $error("lower pointer write did not load address");
	a_load_prefetch: assert property (@(posedge clock) disable iff (!nrst)
		wr_lower |=> host_pend_ff && !host_we_ff && host_addr_ff == ptr_ff)
		else $error("pointer load did not queue prefetch");
	a_auto_increment: assert property (@(posedge clock) disable iff (!nrst)
		(rd_data || wr_data) && upper_ff[7] |=> ptr_ff == $past(ptr_ff) + 11'h001)
		else $error("auto increment missed");
	a_no_increment: assert property (@(posedge clock) disable iff (!nrst)
		(rd_data || wr_data) && !upper_ff[7] && !wr_lower |=> $stable(ptr_ff))
		else $error("pointer moved without auto increment");
	a_write_buffered: assert property (@(posedge clock) disable iff (!nrst)
		wr_data |=> host_we_ff && host_pend_ff && tmp_ff == $past(reg_wdata))
		else $error("host write not held in temporary register");
	a_host_served: assert property (@(posedge clock) disable iff (!nrst)
		host_pend_ff && !reg_wr && !reg_rd ##1 !reg_wr && !reg_rd |=> !host_pend_ff)
		else $error("host byte not served within two cycles");
	a_slow_arb_half: assert property (@(posedge clock) disable iff (!nrst)
		first_setup_register_ff[0] && arb_en && !(reg_wr && reg_addr == OFS_FIRST_SETUP_REGISTER) |=> !arb_en)
		else $error("slow arbitration enable not halved");
	a_data_read: assert property (@(posedge clock) disable iff (!nrst)
		rd_data |=> reg_rdata == $past(tmp_ff))
		else $error("data port read returned wrong byte");
	a_tx_page_start: assert property (@(posedge clock) disable iff (!nrst)
		wr_cmd && reg_wdata[2:0] == 3'h3 |=> tx_pulse_ff &&
		tx_start_ff == {$past(reg_wdata[4:3]), $past(reg_wdata[5]), 8'h00})
		else $error("transmit page start wrong");
	a_node_id_sub: assert property (@(posedge clock) disable iff (!nrst)
		eng_go && !eng_we && eng_tx_read && eng_addr == tx_start_ff
		|=> eng_ack && eng_rdata == $past(node_id_ff))
		else $error("node id not supplied for byte zero");
endmodule
`default_nettype wire

/* rtl/prbacc_pkg.sv */
// Purpose : Shared constants for the pointer driven packet RAM access block
// Assumes : Byte wide register port, 2K x 8 packet RAM
// Notes   : Offsets are byte addresses on the local register port
package prbacc_pkg;
	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] OFS_COMMAND     = 8'h01;
	localparam logic [7:0] OFS_PTR_UPPER   = 8'h02;
	localparam logic [7:0] OFS_PTR_LOWER   = 8'h03;
	localparam logic [7:0] OFS_DATA_PORT   = 8'h04;
	localparam logic [7:0] OFS_NODE_ID     = 8'h05;
	localparam logic [7:0] OFS_PKT_CONFIG  = 8'h06;
	localparam logic [7:0] OFS_FIRST_SETUP_REGISTER      = 8'h07;

	// ****************************************************************
	// Field positions and codes
	// ****************************************************************
	localparam int          UPPER_AUTO_INC_BIT = 7;
	localparam int          FIRST_SETUP_REGISTER_HALVED_ARBITRATION_CLOCK_BIT = 0;
	localparam int          PKTCFG_LONG_BIT    = 1;
	localparam int          CMD_OFFSET_BIT     = 5;
	localparam int          CMD_PAGE_LSB       = 3;
	localparam logic [2:0]  CMD_ENABLE_TX      = 3'h3;
	localparam logic [2:0]  CMD_ENABLE_RX      = 3'h4;
	localparam logic [7:0]  RESET_BYTE         = 8'h00;

	// ****************************************************************
	// Packet layout inside a page
	// ****************************************************************
	localparam logic [10:0] PAGE_BYTES         = 11'h200;
	localparam logic [10:0] HALF_PAGE_BYTES    = 11'h100;
	localparam logic [10:0] HDR_SRC_ID         = 11'h000;
	localparam logic [10:0] HDR_DST_ID         = 11'h001;
	localparam logic [10:0] HDR_SHORT_COUNT    = 11'h002;
	localparam logic [10:0] HDR_LONG_COUNT     = 11'h003;
	localparam logic [9:0]  SHORT_SPAN         = 10'h100;
	localparam logic [9:0]  LONG_SPAN          = 10'h200;
endpackage

/* testbench/pointer_ram_buffer_access_bench.sv */
// Purpose : Self-checking bench for the pointer based packet RAM access
// Assumes : Host strobes one cycle long, read data taken the next cycle
// Notes   : Engine side is driven by the engine model
`timescale 1ns/10ps
`default_nettype none
module pointer_ram_buffer_access_bench;
	import prbacc_pkg::*;
	// ********************
	// Signals
	// ********************
	logic        clock, nrst, reg_wr, reg_rd;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, eng_wdata, eng_rdata;
	logic        eng_req, eng_we, eng_tx_read, eng_ack;
	logic        tx_enable_pulse, rx_enable_pulse, tx_is_long;
	logic [10:0] eng_addr, tx_page_start, rx_page_start, tx_first_data;
	logic [9:0]  tx_data_len;
	int          errors, comparisons, cycles;

	prbacc_core DUT (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .eng_req(eng_req), .eng_we(eng_we),
		.eng_tx_read(eng_tx_read), .eng_addr(eng_addr), .eng_wdata(eng_wdata),
		.eng_ack(eng_ack), .eng_rdata(eng_rdata),
		.tx_enable_pulse(tx_enable_pulse), .rx_enable_pulse(rx_enable_pulse),
		.tx_page_start(tx_page_start), .rx_page_start(rx_page_start),
		.tx_is_long(tx_is_long), .tx_first_data(tx_first_data),
		.tx_data_len(tx_data_len));
	prbacc_engine_model engine (.clock(clock), .eng_req(eng_req),
		.eng_we(eng_we), .eng_tx_read(eng_tx_read), .eng_addr(eng_addr),
		.eng_wdata(eng_wdata), .eng_ack(eng_ack), .eng_rdata(eng_rdata));

	// Free running clock
	always #5 clock = ~clock;

	// Hang guard: the full run needs well under this many cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			final_report;
		end
	end

	// ********************
	// Bus tasks
	// ********************
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Strobes end on the next edge, so tasks may follow each other directly
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
		chk(reg_rdata, e);
	endtask
	task automatic ld(input logic [7:0] up, input logic [7:0] lo);
		wr(OFS_PTR_UPPER, up);
		wr(OFS_PTR_LOWER, lo);
	endtask

	// ********************
	// Scenarios
	// ********************
	task automatic t_reset;
		rchk(OFS_PTR_UPPER, 8'h00);
		rchk(OFS_PTR_LOWER, 8'h00);
		rchk(8'h3F, 8'h00);
		rchk(OFS_COMMAND, 8'h00);
	endtask
	// Stream across a 256 byte boundary, then read it back
	task automatic t_stream;
		int i;
		ld(8'h80, 8'hFE);
		for (i = 0; i < 4; i++)
			wr(OFS_DATA_PORT, 8'(8'hA0 + i));
		rchk(OFS_PTR_UPPER, 8'h81);
		rchk(OFS_PTR_LOWER, 8'h02);
		wr(OFS_PTR_UPPER, 8'h84);
		rchk(OFS_PTR_UPPER, 8'h81);
		ld(8'h80, 8'hFE);
		for (i = 0; i < 4; i++)
			rchk(OFS_DATA_PORT, 8'(8'hA0 + i));
		ld(8'h00, 8'hFF);
		rchk(OFS_DATA_PORT, 8'hA1);
		rchk(OFS_DATA_PORT, 8'hA1);
		rchk(OFS_PTR_LOWER, 8'hFF);
	endtask
	// Halved arbitration needs an extra idle cycle after a pointer load
	task automatic t_slow;
		int i;
		wr(OFS_FIRST_SETUP_REGISTER, 8'h01);
		ld(8'h80, 8'hFE);
		@(posedge clock);
		for (i = 0; i < 4; i++)
			rchk(OFS_DATA_PORT, 8'(8'hA0 + i));
		rchk(OFS_PTR_LOWER, 8'h02);
		wr(OFS_FIRST_SETUP_REGISTER, 8'h00);
	endtask
	// Every page and offset, transmit then receive
	task automatic t_pages;
		int k;
		int hits;
		for (k = 0; k < 16; k++) begin
			hits = 0;
			wr(OFS_COMMAND, {2'b00, k[2], k[1:0], k[3] ? CMD_ENABLE_RX : CMD_ENABLE_TX});
			repeat (3) begin
				@(posedge clock);
				if ((k[3] ? rx_enable_pulse : tx_enable_pulse) === 1'b1)
					hits++;
			end
			chk(16'(hits), 16'h0001);
			chk(k[3] ? rx_page_start : tx_page_start, {k[1:0], k[2], 8'h00});
		end
		wr(OFS_COMMAND, 8'h23);
		repeat (2) @(posedge clock);
		chk(tx_page_start, 11'h100);
	endtask
	// Header decode, node id fill-in and unchecked receive writes
	task automatic t_engine;
		logic [7:0] q;
		wr(OFS_NODE_ID, 8'h3C);
		wr(OFS_PKT_CONFIG, 8'h00);
		wr(OFS_COMMAND, 8'h23);
		ld(8'h81, 8'h00);
		wr(OFS_DATA_PORT, 8'h55);
		wr(OFS_DATA_PORT, 8'hAA);
		wr(OFS_DATA_PORT, 8'hF0);
		wr(OFS_DATA_PORT, 8'h10);
		engine.access(1'b0, 1'b1, 11'h100, 8'h00, q);
		chk(q, 8'h3C);
		engine.access(1'b0, 1'b0, 11'h100, 8'h00, q);
		chk(q, 8'h55);
		engine.access(1'b0, 1'b1, 11'h102, 8'h00, q);
		chk(q, 8'hF0);
		chk({tx_is_long, tx_data_len}, 11'h010);
		chk(tx_first_data, 11'h1F0);
		wr(OFS_PKT_CONFIG, 8'h02);
		ld(8'h81, 8'h02);
		wr(OFS_DATA_PORT, 8'h00);
		engine.access(1'b0, 1'b1, 11'h102, 8'h00, q);
		engine.access(1'b0, 1'b1, 11'h103, 8'h00, q);
		chk({tx_is_long, tx_data_len}, 11'h5F0);
		chk(tx_first_data, 11'h110);
		wr(OFS_COMMAND, 8'h2C);
		engine.access(1'b1, 1'b0, 11'h500, 8'h5A, q);
		ld(8'h85, 8'h00);
		rchk(OFS_DATA_PORT, 8'h5A);
	endtask

	task automatic final_report;
		errors += engine.misses;
		$display("Mismatches %0d, comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		errors = 0;
		comparisons = 0;
		cycles = 0;
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		t_reset;
		t_stream;
		t_slow;
		t_pages;
		t_engine;
		final_report;
	end
endmodule
`default_nettype wire

/* testbench/prbacc_engine_model.sv */
// Purpose : Protocol engine stand-in on the packet RAM side port
// Assumes : One request at a time, held until the acknowledge shows
// Notes   : Released address and data lines show inverted values
`timescale 1ns/10ps
`default_nettype none
module prbacc_engine_model (
	// Clock
	input  wire logic       clock,
	// Engine memory port
	output logic            eng_req,
	output logic            eng_we,
	output logic            eng_tx_read,
	output logic [10:0]     eng_addr,
	output logic [7:0]      eng_wdata,
	input  wire logic       eng_ack,
	input  wire logic [7:0] eng_rdata
);
	// ********************
	// Request driver
	// ********************
	int misses;

	// Idle at time zero so the core sees no request during reset
	initial begin
		misses = 0;
		eng_req = 1'b0;
		eng_we = 1'b0;
		eng_tx_read = 1'b0;
		eng_addr = 11'h000;
		eng_wdata = 8'h00;
	end

	// Ack is sampled at the edge itself; the request holds until that edge
	task automatic access(input logic we, input logic tx, input logic [10:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clock);
		eng_req <= 1'b1;
		eng_we <= we;
		eng_tx_read <= tx;
		eng_addr <= a;
		eng_wdata <= d;
		do begin
			@(posedge clock);
			n++;
		end while (eng_ack !== 1'b1 && n < 16);
		if (eng_ack !== 1'b1) begin
			misses++;
		end
		q = eng_rdata;
		eng_req <= 1'b0;
		eng_addr <= ~a;
		eng_wdata <= ~d;
	endtask
endmodule
`default_nettype wire
